// *** dv/tb_trajectory_start_irq_reset.sv ***
// self-checking bench: host step loop against device over the parallel port
module tb_trajectory_start_irq_reset
   import tsi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [1:0]  addr = 2'h0;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic [7:0]  v;
   logic        moving;
   logic        pos_relative;
   logic [15:0] signals;
   int          fails = 0;
   int          comparisons = 0;
   int          irq_n = 0;

   tsi_port_if port ();
   tsi_device u_tsi_device (.clk(clk), .rst(rst), .port(port), .moving(moving), .pos_relative(pos_relative),
                            .signals(signals));
   // short wait between moves keeps the run small
   tsi_host #(.DELAY_CYC(20)) u_tsi_host (.clk(clk), .rst(rst), .port(port), .addr(addr), .wdata(wdata),
                                          .wr(wr), .rd(rd), .rdata(rdata));
   tsi_port_monitor u_tsi_port_monitor (.clk(clk), .rst(rst), .cs_n(port.cs_n), .port_select_n(port.port_select_n),
      .rd_n(port.rd_n), .wr_n(port.wr_n), .host_d_out(port.host_d_out), .host_d_oe(port.host_d_oe),
      .dev_d_out(port.dev_d_out), .dev_d_oe(port.dev_d_oe), .host_irq(port.host_irq));

   initial begin
      forever #50 clk = ~clk;
   end
   always @(posedge port.host_irq) irq_n++;

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8

   task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : reg_rd

   task automatic give_verdict;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      give_verdict();
   end

   initial begin
      int n;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      reg_rd(TSI_REG_COUNT, v);
      chk8(v, 8'h00);
      reg_rd(TSI_REG_STAT, v);
      chk8(v, 8'h00);
      chk8({7'h00, port.host_irq}, 8'h00);
      reg_wr(TSI_REG_CTRL, 8'h01 << TSI_CTRL_GO);
      reg_rd(TSI_REG_CTRL, v);
      chk8(v & 8'h01, 8'h01);
      // unmapped offset aliases the run bit
      reg_rd(2'h3, v);
      chk8(v & 8'h01, 8'h01);
      n = 0;
      do begin
         reg_rd(TSI_REG_COUNT, v);
         n++;
      end while (v < 8'h03 && n < 5000);
      chk8({7'h00, v >= 8'h03}, 8'h01);
      chk8({7'h00, pos_relative}, 8'h01);
      reg_wr(TSI_REG_CTRL, 8'h01 << TSI_CTRL_STOP);
      repeat (2000) @(posedge clk);
      reg_rd(TSI_REG_CTRL, v);
      chk8(v & 8'h01, 8'h00);
      reg_rd(TSI_REG_COUNT, v);
      chk8(v, irq_n[7:0]);
      chk8({7'h00, port.host_irq}, 8'h00);
      chk8({7'h00, moving}, 8'h00);
      chk8({7'h00, signals[TSI_BIT_HOST_IRQ]}, 8'h00);
      repeat (300) @(posedge clk);
      reg_rd(TSI_REG_COUNT, v);
      chk8(v, irq_n[7:0]);
      give_verdict();
   end
endmodule : tb_trajectory_start_irq_reset

// *** dv/tsi_port_monitor.sv ***
// concurrent checks on the parallel port between host end and device end
module tsi_port_monitor
   import tsi_pkg::*;
(
   input wire logic       clk,           // clock
   input wire logic       rst,           // async reset
   input wire logic       cs_n,          // chip select
   input wire logic       port_select_n, // command/data select
   input wire logic       rd_n,          // read strobe
   input wire logic       wr_n,          // write strobe
   input wire logic [7:0] host_d_out,    // host data
   input wire logic       host_d_oe,     // host drives bus
   input wire logic [7:0] dev_d_out,     // device data
   input wire logic       dev_d_oe,      // device drives bus
   input wire logic       host_irq       // interrupt pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cmd_r;
   logic [7:0] stat_r;
   logic       byte2_r;
   logic       started_r;
   logic       clr_seen_r;
   logic       wr_q_r;
   wire        rd_sel   = !cs_n && !port_select_n && !rd_n;
   wire        wr_go    = !cs_n && !wr_n && !wr_q_r;
   wire        start_go = wr_go && !port_select_n && host_d_out == TSI_CMD_START;
   wire        clr_go   = wr_go && port_select_n && cmd_r == TSI_CMD_IRQ_CLR && byte2_r;

   // stat_r keeps the last status the host saw, so host writes can be judged against it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {cmd_r, stat_r, byte2_r, started_r, clr_seen_r, wr_q_r} <= '0;
      end else begin
         wr_q_r <= !cs_n && !wr_n;
         if (rd_sel && dev_d_oe) stat_r <= dev_d_out;
         if (wr_go) byte2_r <= port_select_n && !byte2_r;
         if (wr_go && !port_select_n) cmd_r <= host_d_out;
         if (start_go || clr_go) started_r <= start_go;
         if (start_go || clr_go) clr_seen_r <= clr_go;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_status_answer: assert property (rd_sel |-> dev_d_oe)
      else $error("status byte not driven");
   a_status_stable: assert property (rd_sel && $past(rd_sel) && $past(dev_d_oe) |-> dev_d_oe && $stable(dev_d_out))
      else $error("status byte moved during read");
   a_single_driver: assert property (!(dev_d_oe && host_d_oe))
      else $error("bus driven by both ends");
   a_write_not_busy: assert property (wr_go |-> !stat_r[TSI_BIT_BUSY])
      else $error("write while busy");
   a_clear_after_done: assert property (wr_go && !port_select_n && host_d_out == TSI_CMD_IRQ_CLR |-> stat_r[TSI_BIT_TRJ_DONE])
      else $error("clear before trajectory done");
   a_move_raises_irq: assert property (start_go |-> ##[1:40] host_irq)
      else $error("no interrupt after start");
   a_irq_has_cause: assert property ($rose(host_irq) |-> started_r)
      else $error("interrupt without start");
   a_clear_drops_irq: assert property (clr_go |-> ##[1:4] !host_irq)
      else $error("interrupt pin not cleared");
   a_irq_fall_cause: assert property ($fell(host_irq) |-> clr_seen_r)
      else $error("interrupt fell without clear");

   c_start: cover property (start_go);
   c_clear: cover property (clr_go);
   c_irq: cover property ($rose(host_irq));
endmodule : tsi_port_monitor

// *** src/tsi_device.sv ***
// device end: command decode, status byte, interrupt flags, host interrupt
//
// The register addresses and the address-and-strobe port were decided locally.
module tsi_device #(
   parameter int BUSY_CYC = tsi_pkg::TSI_BUSY_CYC, // busy hold time
   parameter int MOVE_CYC = tsi_pkg::TSI_MOVE_CYC  // simulated move length
) (
   input  wire logic clk,          // 10 MHz clock
   input  wire logic rst,          // async reset, active high
   tsi_port_if.dev   port,         // host parallel port
   output logic      moving,       // trajectory executing
   output logic      pos_relative, // loaded position is relative
   output logic [15:0] signals     // signals register
);
   import tsi_pkg::*;
   typedef enum logic [1:0] {TSI_D_IDLE = 2'b00, TSI_D_LOAD = 2'b01, TSI_D_CLR = 2'b10} tsi_dst_t;

   tsi_dst_t    st_r;
   logic [7:0]  status_r;
   logic [7:0]  hi_r;
   logic        second_r;
   logic [7:0]  busy_cnt_r;
   logic [7:0]  move_cnt_r;
   logic [3:0]  word_cnt_r;
   logic        loaded_r;
   logic        rel_r;
   logic        moving_r;
   logic        irq_r;
   logic [7:0]  rd_lat_r;
   logic        rd_act_r;
   logic        wr_q_r;

   wire sel       = !port.cs_n;
   wire stat_rd   = sel && !port.port_select_n && !port.rd_n;
   wire wr_now    = sel && !port.wr_n;
   wire wr_edge   = wr_now && !wr_q_r;
   wire busy      = status_r[TSI_BIT_BUSY];
   wire cmd_wr    = wr_edge && !port.port_select_n && !busy;
   wire dat_wr    = wr_edge && port.port_select_n && !busy;
   wire [7:0] din = port.host_d_out;
   wire move_done = moving_r && (move_cnt_r == 8'(MOVE_CYC - 1));
   wire word_done = dat_wr && second_r;
   wire start     = cmd_wr && (din == TSI_CMD_START) && loaded_r;
   wire clr_exec  = word_done && (st_r == TSI_D_CLR);
   // flag bits 1..6 survive only where the word's bit is one; set wins over clear
   wire [7:0] keep_mask = {1'b1, din[TSI_BIT_IRQ_HI:TSI_BIT_IRQ_LO], 1'b1};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q_r <= 1'b0;
      end else begin
         wr_q_r <= wr_now;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r       <= TSI_D_IDLE;
         hi_r       <= 8'h00;
         second_r   <= 1'b0;
         word_cnt_r <= 4'h0;
         loaded_r   <= 1'b0;
         rel_r      <= 1'b0;
      end else begin
         if (cmd_wr) begin
            second_r <= 1'b0;
            word_cnt_r <= 4'h0;
            unique case (din)
               TSI_CMD_TRJ_LOAD: st_r <= TSI_D_LOAD;
               TSI_CMD_IRQ_CLR:  st_r <= TSI_D_CLR;
               default:          st_r <= TSI_D_IDLE;
            endcase
         end else if (dat_wr) begin
            second_r <= !second_r;
            if (!second_r) begin
               hi_r <= din;                                              // upper_byte, unused for clear
            end else if (st_r == TSI_D_LOAD) begin
               if (word_cnt_r == 4'h0) begin
                  rel_r <= (din == TSI_TCW_REL_POS);
               end
               loaded_r   <= 1'b1;
               word_cnt_r <= word_cnt_r + 4'h1;
            end else if (st_r == TSI_D_CLR) begin
               st_r <= TSI_D_IDLE;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_cnt_r <= 8'h00;
         status_r   <= 8'h00;
         moving_r   <= 1'b0;
         move_cnt_r <= 8'h00;
         irq_r      <= 1'b0;
      end else begin
         if (cmd_wr || word_done) begin
            busy_cnt_r <= 8'(BUSY_CYC);
         end else if (busy_cnt_r != 8'h00) begin
            busy_cnt_r <= busy_cnt_r - 8'h01;
         end
         status_r[TSI_BIT_BUSY] <= cmd_wr || word_done || (busy_cnt_r > 8'h01);
         if (start) begin
            moving_r   <= 1'b1;
            move_cnt_r <= 8'h00;
         end else if (move_done) begin
            moving_r <= 1'b0;
         end else if (moving_r) begin
            move_cnt_r <= move_cnt_r + 8'h01;
         end
         if (move_done) begin
            status_r[TSI_BIT_TRJ_DONE] <= 1'b1;
            irq_r <= 1'b1;
         end else if (clr_exec) begin
            status_r[TSI_BIT_IRQ_HI:TSI_BIT_IRQ_LO] <=
               status_r[TSI_BIT_IRQ_HI:TSI_BIT_IRQ_LO] & keep_mask[TSI_BIT_IRQ_HI:TSI_BIT_IRQ_LO];
            irq_r <= 1'b0;
         end
      end
   end

   // the copy follows status while nobody reads and freezes for the strobe, so the
   // first read cycle already shows a current byte and it cannot change mid-strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_act_r <= 1'b0;
         rd_lat_r <= 8'h00;
      end else begin
         rd_act_r <= stat_rd;
         if (!stat_rd) begin
            rd_lat_r <= status_r;
         end
      end
   end

   assign port.dev_d_out = rd_lat_r;
   assign port.dev_d_oe  = stat_rd;
   assign port.host_irq  = irq_r;
   assign moving         = moving_r;
   assign pos_relative   = rel_r;
   assign signals        = {irq_r, 15'h0000};
endmodule : tsi_device

// *** src/tsi_host.sv ***
// host end: step-generation loop driven by software registers
module tsi_host #(
   parameter int DELAY_CYC = tsi_pkg::TSI_DELAY_CYC // wait between moves
) (
   input  wire logic        clk,     // 10 MHz clock
   input  wire logic        rst,     // async reset, active high
   tsi_port_if.host         port,    // device parallel port
   input  wire logic [1:0]  addr,    // register address
   input  wire logic [7:0]  wdata,   // write data
   input  wire logic        wr,      // write strobe
   input  wire logic        rd,      // read strobe
   output logic      [7:0]  rdata    // read data, cycle after rd
);
   import tsi_pkg::*;
   typedef enum logic [2:0] {
      TSI_H_IDLE = 3'b000, TSI_H_START = 3'b001, TSI_H_POLL = 3'b010,
      TSI_H_CLR = 3'b011, TSI_H_HB = 3'b100, TSI_H_LB = 3'b101, TSI_H_WAIT = 3'b110,
      TSI_H_LOAD = 3'b111
   } tsi_hst_t;

   tsi_hst_t    st_r, st_nxt;
   logic [1:0]  ph_r;
   logic        run_r;
   logic [7:0]  count_r;
   logic [31:0] dly_r;
   logic [7:0]  last_stat_r;
   logic [7:0]  rdata_r;
   logic        cs_n_r, ps_n_r, rd_n_r, wr_n_r, oe_r;
   logic [7:0]  dout_r;
   logic [3:0]  ld_idx_r;
   logic        ld_done_r;

   wire go_wr   = wr && (addr == TSI_REG_CTRL) && wdata[TSI_CTRL_GO];
   wire stop_wr = wr && (addr == TSI_REG_CTRL) && wdata[TSI_CTRL_STOP];
   wire [7:0] sbyte = port.dev_d_out;
   wire is_write = (st_r == TSI_H_START) || (st_r == TSI_H_CLR) || (st_r == TSI_H_HB) || (st_r == TSI_H_LB) ||
                   (st_r == TSI_H_LOAD);
   // load byte 0 is the command, then word pairs; the control word's lower byte is byte 2
   wire ld_last  = (ld_idx_r == 4'(2 * TSI_LOAD_WORDS));
   wire ps_data  = (st_r == TSI_H_HB) || (st_r == TSI_H_LB) || ((st_r == TSI_H_LOAD) && (ld_idx_r != 4'h0));
   wire [7:0] ld_byte = (ld_idx_r == 4'h0) ? TSI_CMD_TRJ_LOAD :
                        (ld_idx_r == 4'h2) ? TSI_TCW_REL_POS : 8'h00;
   wire [7:0] wbyte = (st_r == TSI_H_START) ? TSI_CMD_START :
                      (st_r == TSI_H_LOAD)  ? ld_byte :
                      (st_r == TSI_H_CLR)   ? TSI_CMD_IRQ_CLR : TSI_IRQ_ALL_CLR;
   wire [7:0] reg_rd = (addr == TSI_REG_STAT)  ? last_stat_r :
                       (addr == TSI_REG_COUNT) ? count_r : {7'h00, run_r};

   // each write step: phase0 poll busy, phase1 sample, phase2 strobe write, phase3 release
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         TSI_H_IDLE:  if (run_r) st_nxt = ld_done_r ? TSI_H_START : TSI_H_LOAD;
         TSI_H_LOAD:  if (ph_r == 2'h3 && ld_last) st_nxt = TSI_H_START;
         TSI_H_START: if (ph_r == 2'h3) st_nxt = TSI_H_POLL;
         TSI_H_POLL:  if (ph_r == 2'h1 && sbyte[TSI_BIT_TRJ_DONE]) st_nxt = TSI_H_CLR;
         TSI_H_CLR:   if (ph_r == 2'h3) st_nxt = TSI_H_HB;
         TSI_H_HB:    if (ph_r == 2'h3) st_nxt = TSI_H_LB;
         TSI_H_LB:    if (ph_r == 2'h3) st_nxt = TSI_H_WAIT;
         TSI_H_WAIT:  if (dly_r == 32'h0) st_nxt = run_r ? TSI_H_START : TSI_H_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= TSI_H_IDLE;
         ph_r <= 2'h0;
         dly_r <= 32'h0;
         ld_idx_r <= 4'h0;
         ld_done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (st_r == TSI_H_LOAD && ph_r == 2'h3) begin
            ld_idx_r <= ld_idx_r + 4'h1;
            ld_done_r <= ld_last;
         end
         if (st_nxt != st_r) begin
            ph_r <= 2'h0;
         end else if (is_write && ph_r == 2'h1 && sbyte[TSI_BIT_BUSY]) begin
            ph_r <= 2'h0;
         end else if (st_r == TSI_H_POLL && ph_r == 2'h1) begin
            ph_r <= 2'h0;
         end else begin
            ph_r <= ph_r + 2'h1;
         end
         if (st_r == TSI_H_LB && st_nxt == TSI_H_WAIT) begin
            dly_r <= 32'(DELAY_CYC);
         end else if (dly_r != 32'h0) begin
            dly_r <= dly_r - 32'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_n_r <= 1'b1; ps_n_r <= 1'b0; rd_n_r <= 1'b1; wr_n_r <= 1'b1;
         oe_r <= 1'b0; dout_r <= 8'h00; last_stat_r <= 8'h00;
      end else begin
         cs_n_r <= !(st_r != TSI_H_IDLE && st_r != TSI_H_WAIT);
         ps_n_r <= ps_data && ph_r[1];
         // one-cycle reads let the device refresh its frozen byte between polls
         rd_n_r <= !(st_r != TSI_H_IDLE && st_r != TSI_H_WAIT && ph_r == 2'h0);
         wr_n_r <= !(is_write && ph_r == 2'h2);
         oe_r   <= is_write && ph_r[1];
         dout_r <= wbyte;
         if (ph_r == 2'h1 && !rd_n_r) last_stat_r <= sbyte;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_r <= 1'b0; count_r <= 8'h00; rdata_r <= 8'h00;
      end else begin
         run_r <= go_wr ? 1'b1 : (stop_wr ? 1'b0 : run_r);
         if (st_r == TSI_H_LB && st_nxt == TSI_H_WAIT) count_r <= count_r + 8'h01;
         rdata_r <= rd ? reg_rd : 8'h00;
      end
   end

   assign port.cs_n          = cs_n_r;
   assign port.port_select_n = ps_n_r;
   assign port.rd_n          = rd_n_r;
   assign port.wr_n          = wr_n_r;
   assign port.host_d_out    = dout_r;
   assign port.host_d_oe     = oe_r;
   assign rdata              = rdata_r;
endmodule : tsi_host

// *** src/tsi_pkg.sv ***
// shared constants for the trajectory-start / interrupt-clear command port
package tsi_pkg;
   localparam logic [7:0] TSI_CMD_START     = 8'h01;
   localparam logic [7:0] TSI_CMD_IRQ_CLR   = 8'h1D;
   localparam logic [7:0] TSI_CMD_TRJ_LOAD  = 8'h1F;
   localparam logic [7:0] TSI_TCW_REL_POS   = 8'h2B;
   localparam logic [7:0] TSI_IRQ_ALL_CLR   = 8'h00;
   localparam int         TSI_BIT_BUSY      = 0;
   localparam int         TSI_BIT_IRQ_LO    = 1;
   localparam int         TSI_BIT_IRQ_HI    = 6;
   localparam int         TSI_BIT_TRJ_DONE  = 2;
   localparam int         TSI_BIT_HOST_IRQ  = 15;
   localparam int         TSI_BUSY_CYC      = 4;
   localparam int         TSI_MOVE_CYC      = 16;
   localparam int         TSI_LOAD_WORDS    = 7;
   localparam int         TSI_CLK_HZ        = 10000000;
   localparam int         TSI_DELAY_MS      = 5;
   localparam int         TSI_DELAY_CYC     = TSI_DELAY_MS * (TSI_CLK_HZ / 1000);
   // controller register offsets
   localparam logic [1:0] TSI_REG_CTRL      = 2'h0;
   localparam logic [1:0] TSI_REG_STAT      = 2'h1;
   localparam logic [1:0] TSI_REG_COUNT     = 2'h2;
   localparam int         TSI_CTRL_GO       = 0;
   localparam int         TSI_CTRL_STOP     = 1;
endpackage : tsi_pkg

// *** src/tsi_port_if.sv ***
// parallel host port shared by controller and device
interface tsi_port_if;
   logic       cs_n;         // chip select
   logic       port_select_n;// low: command/status, high: data
   logic       rd_n;         // read strobe
   logic       wr_n;         // write strobe
   logic [7:0] host_d_out;   // host data drive
   logic       host_d_oe;    // host drives bus
   logic [7:0] dev_d_out;    // device data drive
   logic       dev_d_oe;     // device drives bus
   logic       host_irq;     // device interrupt to host
   wire  [7:0] d = host_d_oe ? host_d_out : (dev_d_oe ? dev_d_out : 8'hFF);
   modport dev  (input cs_n, port_select_n, rd_n, wr_n, host_d_out, host_d_oe,
                 output dev_d_out, dev_d_oe, host_irq);
   modport host (output cs_n, port_select_n, rd_n, wr_n, host_d_out, host_d_oe,
                 input dev_d_out, dev_d_oe, host_irq);
endinterface : tsi_port_if
